// >>> tri_pkg.sv
// Constants, field layout and carrier types of the result and flag bank
//------------------------------------------------------------------------------
// Summary of operation
// (R1) Cause 0: first result after run interrupts
// (R2) Cause 0: finished offset calibration interrupts
// (R3) Cause 1: consecutive over-threshold results flag channel
// (R4) Drift overflow interrupts in either cause setting
// (R5) Depth code selects averaging over 1/2/4/8
// (R6) Missing history slots filled with first result
// (R7) Full history: mean of N newest results
// (R8) Low latch 0x03 drives outputs 0-7
// (R9) High latch 0x04 bits 5:0 drive 8-13
// (R10) Register 0x05 holds touch flags 0-7
// (R11) Register 0x06 bits 5:0 hold flags 8-13
// (R12) Bit 7 of 0x06 flags drift overflow
// (R13) Single-byte read of 0x06 clears everything
// (R14) Sequential read of 0x06 clears nothing
// (R15) Result is raw plus static plus dynamic offset
// (R16) Results are 16-bit two's complement
// (R17) Upper bytes first, lower bytes follow, input order
// (R18) Differential pair: odd slot mirrors even result
// (R19) Drift overflow interrupts only when enabled
// (R20) Touch flag needs channel interrupt enable
// (R21) Flags and interrupt stay until clearing read
// (R22) Both result bytes updated from one value
//------------------------------------------------------------------------------
package tri_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CFG2     = 8'h02;
  localparam logic [7:0] ADDR_LAT_LO   = 8'h03;
  localparam logic [7:0] ADDR_LAT_HI   = 8'h04;
  localparam logic [7:0] ADDR_FLG_LO   = 8'h05;
  localparam logic [7:0] ADDR_FLG_HI   = 8'h06;
  localparam logic [7:0] ADDR_RES_HI0  = 8'h07;
  localparam logic [7:0] ADDR_RES_LO0  = 8'h15;
  localparam logic [7:0] ADDR_RES_LAST = 8'h22;

  // Reset values and writable masks
  localparam logic [7:0] CFG2_RST      = 8'h00;
  localparam logic [7:0] CFG2_WMASK    = 8'hbf;
  localparam logic [7:0] LAT_RST       = 8'h00;
  localparam logic [7:0] LAT_HI_MASK   = 8'h3f;

  // Field positions inside the configuration and flag bytes
  localparam int CFG2_DRIFT_EN_BIT = 4;
  localparam int CFG2_POL_BIT      = 3;
  localparam int CFG2_SEL_BIT      = 2;
  localparam int CFG2_AVG_LSB      = 0;
  localparam int FLG_DRIFT_BIT     = 7;

  // Sizes
  localparam int NUM_CH     = 14;
  localparam int NUM_PAIRS  = 7;
  localparam int HIST_DEPTH = 8;
  localparam logic [3:0] FILL_FULL = 4'h8;
  localparam logic [3:0] CNT_MAX   = 4'hf;

  // One sample handed over by the front end
  typedef struct packed {
    logic        [3:0]  chan;
    logic signed [15:0] raw;
    logic signed [15:0] static_off;
    logic signed [15:0] dyn_off;
  } tri_sample_t;

  // Result pipeline states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_HIST  = 3'b010,
    ST_STORE = 3'b100
  } tri_state_t;

endpackage

// >>> tri_result_irq_regs.sv
// Result averaging, touch and drift flags, output latches and register reads
`timescale 1ns/10ps
module tri_result_irq_regs (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Register port from the serial slave (same clock)
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  input  wire logic                reg_rd_single,
  output logic      [7:0]          reg_rdata,
  // Front end link (foreign clock)
  input  wire logic                meas_clk,
  input  wire tri_pkg::tri_sample_t meas_sample,
  // Engine events (same clock, one-cycle pulses)
  input  wire logic                run_start,
  input  wire logic                cal_done,
  input  wire logic                drift_overflow,
  // Channel configuration: per pair, per channel and shared (same clock, levels)
  input  wire logic [6:0]          diff_mode,
  input  wire logic [13:0]         channel_irq_enable,
  input  wire logic signed [15:0]  touch_threshold,
  input  wire logic [3:0]          touch_count,
  // Pins
  output logic      [13:0]         out_pin_level,
  output logic                     irq_out
);

  //----------------------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------------------
  logic [7:0]         cfg2_q;                 // Cause, drift enable, depth
  logic [7:0]         lat_lo_q;               // Output levels 0-7
  logic [7:0]         lat_hi_q;               // Output levels 8-13
  logic [13:0]        flag_q;                 // Touch flags
  logic               drift_flag_q;           // Drift overflow flag
  logic               irq_q;                  // Internal active-high request
  logic               irq_pin_q;              // Polarity-applied pin level
  logic               first_pend_q;           // Awaiting first result of run
  logic [7:0]         rdata_q;                // Read data
  // Per-channel results, history and counters
  logic signed [15:0] res_q [tri_pkg::NUM_CH];      // Averaged results
  logic signed [15:0] hist_q [tri_pkg::NUM_CH][tri_pkg::HIST_DEPTH];
  logic [3:0]         fill_q [tri_pkg::NUM_CH];     // Results seen this run
  logic [3:0]         consec_q [tri_pkg::NUM_CH];   // Over-threshold run
  tri_pkg::tri_state_t st_q;                  // Pipeline state
  logic [3:0]         ch_q;                   // Channel in flight
  logic signed [15:0] val_q;                  // Summed sample in flight

  //----------------------------------------------------------------------------
  // Link synchronisers
  //----------------------------------------------------------------------------
  // Clock and data are both double-flopped; the front end holds data
  // steady across its edge so both arrive together.
  logic                 mclk_s1_q;
  logic                 mclk_s2_q;
  logic                 mclk_s3_q;
  tri_pkg::tri_sample_t msmp_s1_q;
  tri_pkg::tri_sample_t msmp_s2_q;
  // Stage three only marks the edge; logic reads stage two

  // Two-stage capture of link signals
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
      msmp_s1_q <= '0;
      msmp_s2_q <= '0;
    end else begin
      mclk_s1_q <= meas_clk;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
      msmp_s1_q <= meas_sample;
      msmp_s2_q <= msmp_s1_q;
    end
  end

  //----------------------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------------------
  // Address match, reused for writes, reads and the clear
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire       meas_edge_w = mclk_s2_q & ~mclk_s3_q;   // Rising link edge
  wire [3:0] in_ch_w     = msmp_s2_q.chan;
  // Channel numbers past the last input are ignored
  wire       ch_ok_w     = (in_ch_w < 4'(tri_pkg::NUM_CH));
  // Odd member of a differential pair carries no own sample
  wire       odd_diff_w  = in_ch_w[0] & diff_mode[in_ch_w[3:1]];
  wire       accept_w    = meas_edge_w & ch_ok_w & ~odd_diff_w &
                           (st_q == tri_pkg::ST_IDLE);
  // Sum wraps to 16 bits as two's complement  [R15] [R16]
  wire signed [15:0] sum_in_w = 16'(msmp_s2_q.raw + msmp_s2_q.static_off +
                                    msmp_s2_q.dyn_off);

  // Configuration fields
  wire       sel_w      = cfg2_q[tri_pkg::CFG2_SEL_BIT];
  wire       drift_en_w = cfg2_q[tri_pkg::CFG2_DRIFT_EN_BIT];
  wire       pol_w      = cfg2_q[tri_pkg::CFG2_POL_BIT];
  wire [1:0] depth_w    = cfg2_q[tri_pkg::CFG2_AVG_LSB +: 2];
  wire [3:0] n_slots_w  = 4'h1 << depth_w;                     // [R5]

  // Write strobes; all other addresses are read-only
  wire wr_cfg2_w   = reg_wr & hit(reg_addr, tri_pkg::ADDR_CFG2);
  wire wr_lat_lo_w = reg_wr & hit(reg_addr, tri_pkg::ADDR_LAT_LO);
  wire wr_lat_hi_w = reg_wr & hit(reg_addr, tri_pkg::ADDR_LAT_HI);
  // Only a standalone byte read clears; burst reads leave flags  [R13] [R14]
  wire clear_w     = reg_rd & reg_rd_single &
                     hit(reg_addr, tri_pkg::ADDR_FLG_HI);

  //----------------------------------------------------------------------------
  // Moving average
  //----------------------------------------------------------------------------
  // Slots beyond depth N contribute nothing
  logic signed [15:0] slot_w [tri_pkg::HIST_DEPTH];
  genvar gk;
  generate
    for (gk = 0; gk < tri_pkg::HIST_DEPTH; gk++) begin : g_slot
      assign slot_w[gk] = (4'(gk) < n_slots_w) ? hist_q[ch_q][gk] : 16'sh0;
    end
  endgenerate

  // Nineteen bits hold eight full-scale samples
  logic signed [18:0] win_sum;
  // Sum of the N newest slots  [R7]
  always_comb begin
    win_sum = 19'sh0;
    for (int k = 0; k < tri_pkg::HIST_DEPTH; k++) begin
      win_sum = win_sum + 19'(slot_w[k]);
    end
  end
  // Divide by N as arithmetic shift  [R5]
  wire signed [18:0] avg_full_w = win_sum >>> depth_w;
  // Mean of 16-bit samples always fits 16 bits
  wire signed [15:0] avg_w      = avg_full_w[15:0];

  //----------------------------------------------------------------------------
  // Threshold run detection
  //----------------------------------------------------------------------------
  wire       over_w    = (avg_w > touch_threshold);
  // A zero count would fire on every result; treat it as one
  wire [3:0] need_w    = (touch_count == 4'h0) ? 4'h1 : touch_count;
  // Saturating run count cannot wrap back to zero
  wire [3:0] cnt_nx_w  = !over_w ? 4'h0 :
                         (consec_q[ch_q] == tri_pkg::CNT_MAX) ?
                         tri_pkg::CNT_MAX : consec_q[ch_q] + 4'h1;
  wire       store_w   = (st_q == tri_pkg::ST_STORE);
  // Consecutive count reached, cause 1, channel enabled  [R3] [R20]
  wire       touch_w   = store_w & sel_w & channel_irq_enable[ch_q] &
                         (cnt_nx_w >= need_w);
  wire [13:0] touch_set_w = touch_w ? (14'h1 << ch_q) : 14'h0;
  wire       first_w   = store_w & first_pend_q;

  // Cause 0 events have no status bit, only the pin
  // Interrupt sources
  wire irq_set_w = (|touch_set_w) |                              // [R3]
                   (~sel_w & first_w) |                          // [R1]
                   (~sel_w & cal_done) |                         // [R2]
                   (drift_overflow & drift_en_w);                // [R4] [R19]
  // Set beats a simultaneous clear  [R21]
  wire irq_d_w = (irq_q & ~clear_w) | irq_set_w;

  //----------------------------------------------------------------------------
  // Read mux
  //----------------------------------------------------------------------------
  // Result window: upper bytes, then lower bytes
  wire       in_hi_w  = (reg_addr >= tri_pkg::ADDR_RES_HI0) &
                        (reg_addr <  tri_pkg::ADDR_RES_LO0);
  wire       in_lo_w  = (reg_addr >= tri_pkg::ADDR_RES_LO0) &
                        (reg_addr <= tri_pkg::ADDR_RES_LAST);
  // Byte index inside each half of the window
  wire [7:0] hi_idx_w = reg_addr - tri_pkg::ADDR_RES_HI0;
  wire [7:0] lo_idx_w = reg_addr - tri_pkg::ADDR_RES_LO0;

  logic [7:0] rd_mux;
  // Upper bytes first, then lower bytes, in input order  [R17]
  always_comb begin
    rd_mux = 8'h00;
    if (hit(reg_addr, tri_pkg::ADDR_CFG2)) begin
      rd_mux = cfg2_q;
    end else if (hit(reg_addr, tri_pkg::ADDR_LAT_LO)) begin
      rd_mux = lat_lo_q;
    end else if (hit(reg_addr, tri_pkg::ADDR_LAT_HI)) begin
      rd_mux = lat_hi_q;
    end else if (hit(reg_addr, tri_pkg::ADDR_FLG_LO)) begin
      rd_mux = flag_q[7:0];                                     // [R10]
    end else if (hit(reg_addr, tri_pkg::ADDR_FLG_HI)) begin
      rd_mux = {drift_flag_q, 1'b0, flag_q[13:8]};              // [R11] [R12]
    end else if (in_hi_w) begin
      rd_mux = res_q[hi_idx_w[3:0]][15:8];
    end else if (in_lo_w) begin
      rd_mux = res_q[lo_idx_w[3:0]][7:0];
    end
  end

  //----------------------------------------------------------------------------
  // Registers written by software
  //----------------------------------------------------------------------------
  // Configuration byte and output latches
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg2_q   <= tri_pkg::CFG2_RST;
      lat_lo_q <= tri_pkg::LAT_RST;
      lat_hi_q <= tri_pkg::LAT_RST;
    end else begin
      if (wr_cfg2_w) begin
        cfg2_q <= reg_wdata & tri_pkg::CFG2_WMASK;
      end
      if (wr_lat_lo_w) begin
        lat_lo_q <= reg_wdata;                                  // [R8]
      end
      if (wr_lat_hi_w) begin
        lat_hi_q <= reg_wdata & tri_pkg::LAT_HI_MASK;           // [R9]
      end
    end
  end

  //----------------------------------------------------------------------------
  // Flags, interrupt and read data
  //----------------------------------------------------------------------------
  // Sticky flags; hardware set wins over the clearing read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_q       <= 14'h0;
      drift_flag_q <= 1'b0;
      irq_q        <= 1'b0;
      irq_pin_q    <= 1'b0;
      rdata_q      <= 8'h00;
    end else begin
      flag_q       <= (clear_w ? 14'h0 : flag_q) | touch_set_w;   // [R21]
      drift_flag_q <= (drift_flag_q & ~clear_w) | drift_overflow; // [R12]
      irq_q        <= irq_d_w;
      // Polarity applied in the flop, so no pin glitch
      irq_pin_q    <= irq_d_w ^ pol_w;
      rdata_q      <= rd_mux;
    end
  end

  // Pending first result of a run
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_pend_q <= 1'b0;
    end else begin
      // Re-armed by every run start
      first_pend_q <= run_start | (first_pend_q & ~store_w);     // [R1]
    end
  end

  //----------------------------------------------------------------------------
  // Result pipeline
  //----------------------------------------------------------------------------
  // Idle -> write history -> compute and store; samples arriving while
  // busy are dropped, the link rate is far below three clock cycles.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= tri_pkg::ST_IDLE;
      ch_q  <= 4'h0;
      val_q <= 16'sh0;
    end else begin
      case (st_q)
        tri_pkg::ST_IDLE: begin
          if (accept_w) begin
            st_q  <= tri_pkg::ST_HIST;
            ch_q  <= in_ch_w;
            val_q <= sum_in_w;
          end
        end
        tri_pkg::ST_HIST:  st_q <= tri_pkg::ST_STORE;
        tri_pkg::ST_STORE: st_q <= tri_pkg::ST_IDLE;
        default:           st_q <= tri_pkg::ST_IDLE;
      endcase
    end
  end

  // Sample history; first result of a run fills every slot  [R6]
  // No reset: the first result of a run rebuilds it
  always_ff @(posedge clock) begin
    if (st_q == tri_pkg::ST_HIST) begin
      // Newest sample always lands in slot zero
      hist_q[ch_q][0] <= val_q;
      for (int k = 1; k < tri_pkg::HIST_DEPTH; k++) begin
        if (fill_q[ch_q] == 4'h0) begin
          hist_q[ch_q][k] <= val_q;
        end else begin
          hist_q[ch_q][k] <= hist_q[ch_q][k-1];
        end
      end
    end
  end

  // Per-channel fill count and consecutive counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < tri_pkg::NUM_CH; c++) begin
        fill_q[c]   <= 4'h0;
        consec_q[c] <= 4'h0;
      end
    end else if (run_start) begin
      // New run: history and runs start over
      for (int c = 0; c < tri_pkg::NUM_CH; c++) begin
        fill_q[c]   <= 4'h0;
        consec_q[c] <= 4'h0;
      end
    end else begin
      // Fill count saturates at full depth
      if (st_q == tri_pkg::ST_HIST && fill_q[ch_q] != tri_pkg::FILL_FULL) begin
        fill_q[ch_q] <= fill_q[ch_q] + 4'h1;
      end
      if (store_w) begin
        consec_q[ch_q] <= cnt_nx_w;                             // [R3]
      end
    end
  end

  // Results read zero until a channel's first sample
  // Whole 16-bit word written at once, so both bytes agree  [R22]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < tri_pkg::NUM_CH; c++) begin
        res_q[c] <= 16'sh0;
      end
    end else if (store_w) begin
      res_q[ch_q] <= avg_w;
      // Differential result mirrored into the odd slot  [R18]
      if (!ch_q[0] && diff_mode[ch_q[3:1]]) begin
        res_q[ch_q + 4'h1] <= avg_w;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  // Every pin and the read port come from a flop
  assign reg_rdata     = rdata_q;
  assign out_pin_level = {lat_hi_q[5:0], lat_lo_q};             // [R8] [R9]
  assign irq_out       = irq_pin_q;

endmodule // tri_result_irq_regs

// >>> tri_result_irq_regs_chk.sv
// Port assertions for the result and flag bank
`timescale 1ns/10ps
module tri_result_irq_regs_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic        reg_rd_single,
  input wire logic [7:0]  reg_rdata,
  // Link and events
  input wire logic        meas_clk,
  input wire logic        run_start,
  input wire logic        cal_done,
  input wire logic        drift_overflow,
  // Pins
  input wire logic [13:0] out_pin_level,
  input wire logic        irq_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  //----------------------------------------------------------------------
  // Helper logic
  //----------------------------------------------------------------------
  logic [7:0] cfg_q;   // Shadow of configuration byte
  logic [3:0] quiet_q; // Idle link cycles, saturates at 8
  logic       pol_q;   // Polarity the pin flop last applied
  wire clr = reg_rd && reg_rd_single && reg_addr == tri_pkg::ADDR_FLG_HI;
  wire act = irq_out ^ pol_q; // Request level with polarity removed
  // Shadow tracks writes so cause and enable are known here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q   <= 8'h00;
      quiet_q <= 4'h0;
      pol_q   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == tri_pkg::ADDR_CFG2)
        cfg_q <= reg_wdata & tri_pkg::CFG2_WMASK;
      quiet_q <= meas_clk ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'h8};
      pol_q   <= cfg_q[tri_pkg::CFG2_POL_BIT];
    end
  end
  //----------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------
  property p_lat_lo;
    reg_wr && reg_addr == 8'h03 |=> out_pin_level[7:0] == $past(reg_wdata);
  endproperty
  a_lat_lo: assert property (p_lat_lo)
    else $error("low pins wrong");
  property p_lat_hi;
    reg_wr && reg_addr == 8'h04
      |=> out_pin_level[13:8] == $past(reg_wdata[5:0]);
  endproperty
  a_lat_hi: assert property (p_lat_hi)
    else $error("high pins wrong");
  property p_pins_hold;
    !(reg_wr && (reg_addr == 8'h03 || reg_addr == 8'h04))
      |=> $stable(out_pin_level);
  endproperty
  a_pins_hold: assert property (p_pins_hold)
    else $error("pins moved");
  property p_rd_lo;
    reg_addr == 8'h03 |=> reg_rdata == $past(out_pin_level[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low latch readback");
  property p_rd_hi;
    reg_addr == 8'h04 |=> reg_rdata == {2'b00, $past(out_pin_level[13:8])};
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("high latch readback");
  property p_cal_irq;
    cal_done && !cfg_q[tri_pkg::CFG2_SEL_BIT] |=> act;
  endproperty
  a_cal_irq: assert property (p_cal_irq)
    else $error("no calibration irq");
  property p_drift_irq;
    drift_overflow && cfg_q[tri_pkg::CFG2_DRIFT_EN_BIT] |=> act;
  endproperty
  a_drift_irq: assert property (p_drift_irq)
    else $error("no drift irq");
  property p_drift_off;
    drift_overflow && !cfg_q[tri_pkg::CFG2_DRIFT_EN_BIT] && !act
      && !cal_done && !run_start && quiet_q == 4'h8 |=> !act;
  endproperty
  a_drift_off: assert property (p_drift_off)
    else $error("masked drift irq");
  property p_irq_hold;
    act && !clr |=> act;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped");
  property p_clear;
    clr && !cal_done && !drift_overflow && !run_start && quiet_q == 4'h8
      |=> !act;
  endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
endmodule // tri_result_irq_regs_chk

bind tri_result_irq_regs tri_result_irq_regs_chk tri_result_irq_regs_chk_inst (
  .clock, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_single,
  .reg_rdata, .meas_clk, .run_start, .cal_done, .drift_overflow,
  .out_pin_level, .irq_out
);

// >>> tri_front_end.sv
// Front-end model presenting samples on the foreign-clock link
`timescale 1ns/10ps
module tri_front_end (
  // Link outputs
  output logic                 meas_clk,
  output tri_pkg::tri_sample_t meas_sample
);
  // Link clock stands low between samples
  initial begin
    meas_clk    = 1'b0;
    meas_sample = '0;
  end
  // One sample per 64 ns period, held well around the rising edge
  task automatic send(input tri_pkg::tri_sample_t s);
    meas_sample = s;
    #16 meas_clk = 1'b1;
    #32 meas_clk = 1'b0;
    #16 meas_sample = ~s; // Stale lines must not look valid
  endtask
endmodule // tri_front_end

// >>> tb_tri_result_irq_regs.sv
// Self-checking bench for the result and flag bank
`timescale 1ns/10ps
module tb_tri_result_irq_regs;
  //----------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------
  logic                 clock = 1'b0;
  logic                 arst_n = 1'b0;
  logic [7:0]           reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic                 reg_wr = 1'b0, reg_rd = 1'b0, reg_rd_single = 1'b1;
  logic                 meas_clk, irq_out;
  tri_pkg::tri_sample_t meas_sample;
  logic                 run_start = 1'b0, cal_done = 1'b0;
  logic                 drift_overflow = 1'b0;
  logic [6:0]           diff_mode = 7'h00;
  logic [13:0]          channel_irq_enable = 14'h0000, out_pin_level;
  logic signed [15:0]   touch_threshold = 16'sh0000;
  logic [3:0]           touch_count = 4'h0, c;
  logic [15:0]          exp_q [$];     // Pending {address, byte} reads
  logic                 rd_mark = 1'b0, mark_d1 = 1'b0;
  logic signed [15:0]   v, e, hist [8];
  logic signed [18:0]   acc;
  int                   num_errors = 0, n_checks = 0;

  always #2.5 clock = ~clock;

  tri_result_irq_regs tri_result_irq_regs_inst (.clock, .arst_n, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rd_single, .reg_rdata, .meas_clk,
    .meas_sample, .run_start, .cal_done, .drift_overflow, .diff_mode,
    .channel_irq_enable, .touch_threshold, .touch_count, .out_pin_level,
    .irq_out);
  tri_front_end tri_front_end_inst (.meas_clk, .meas_sample);
  //----------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] x, y);
    n_checks++;
    if (y !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, x, y);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read with the expected byte queued for the monitor
  task automatic rd(input logic [7:0] a, x, input logic s = 1'b1);
    @(posedge clock);
    {reg_addr, reg_rd, reg_rd_single, rd_mark} <= {a, 1'b1, s, 1'b1};
    exp_q.push_back({a, x});
    @(posedge clock);
    {reg_rd, rd_mark} <= 2'b00;
  endtask
  // Event pulse: 0 run start, 1 calibration done, 2 drift overflow
  task automatic ev(input int k);
    @(posedge clock);
    {drift_overflow, cal_done, run_start} <= 3'(1 << k);
    @(posedge clock);
    {drift_overflow, cal_done, run_start} <= 3'b000;
  endtask
  task automatic irq_is(input logic x);
    @(posedge clock);
    cmp("irq", {15'h0, x}, {15'h0, irq_out});
  endtask
  // Random split of the wanted sum over raw and both offsets
  task automatic put(input logic [3:0] ch, input logic signed [15:0] val);
    logic signed [15:0] a, b;
    a = 16'($urandom);
    b = 16'($urandom);
    tri_front_end_inst.send('{ch, val - a - b, a, b});
    repeat (8) @(posedge clock);
  endtask
  //----------------------------------------------------------------------
  // Monitor: read data lands two edges after the strobe edge
  //----------------------------------------------------------------------
  always @(posedge clock) begin
    if (mark_d1 && exp_q.size() > 0) begin
      cmp("reg", exp_q[0], {exp_q[0][15:8], reg_rdata});
      void'(exp_q.pop_front());
    end
    mark_d1 <= rd_mark;
  end
  initial begin
    #200000;
    cmp("watchdog", 16'h0001, 16'h0000);
    stop_test();
  end
  //----------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hbdd2));
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h06, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      wr(8'h03, v[7:0]);
      wr(8'h04, v[15:8]);
      rd(8'h03, v[7:0]);
      rd(8'h04, v[15:8] & 8'h3f);
      cmp("pins", {2'b00, v[13:8], v[7:0]}, {2'b00, out_pin_level});
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    rd(8'h40, 8'h00);
    $display("test latches done");
    for (int d = 0; d < 4; d++) begin
      c = 4'($urandom % 14);
      wr(8'h02, 8'(d));
      ev(0);
      for (int k = 0; k < 9; k++) begin
        v = k == 1 ? 16'sh7fff : k == 2 ? 16'sh8000 : 16'($urandom);
        for (int j = 7; j > 0; j--)
          hist[j] = k == 0 ? v : hist[j-1];
        hist[0] = v;
        acc = '0;
        for (int j = 0; j < (1 << d); j++)
          acc += hist[j];
        e = 16'(acc >>> d);
        put(c, v);
        rd(8'h07 + {4'h0, c}, e[15:8]);
        rd(8'h15 + {4'h0, c}, e[7:0]);
        irq_is(k == 0);
        if (k == 0)
          rd(8'h06, 8'h00);
      end
    end
    $display("test averaging done");
    wr(8'h02, 8'h00);
    diff_mode <= 7'h08;
    put(4'd6, 16'sh1234);
    put(4'd7, 16'sh5678);
    rd(8'h0e, 8'h12);
    rd(8'h1c, 8'h34);
    rd(8'h0d, 8'h12);
    $display("test differential done");
    ev(1);
    irq_is(1'b1);
    rd(8'h06, 8'h00);
    irq_is(1'b0);
    ev(2);
    irq_is(1'b0);
    rd(8'h06, 8'h80, 1'b0);
    rd(8'h06, 8'h80);
    rd(8'h06, 8'h00);
    wr(8'h02, 8'h10);
    ev(2);
    irq_is(1'b1);
    rd(8'h06, 8'h80, 1'b0);
    irq_is(1'b1);
    rd(8'h06, 8'h80);
    irq_is(1'b0);
    // Low-active pin: an asserted request reads as zero
    wr(8'h02, 8'h18);
    ev(2);
    irq_is(1'b0);
    rd(8'h06, 8'h80);
    irq_is(1'b1);
    wr(8'h02, 8'h00);
    $display("test events done");
    wr(8'h02, 8'h04);
    {diff_mode, channel_irq_enable} <= {7'h00, 14'h0204};
    {touch_threshold, touch_count} <= {16'sd100, 4'h3};
    ev(0);
    for (int k = 0; k < 5; k++) begin
      put(4'd9, k == 1 ? 16'sd100 : 16'sd200);
      irq_is(k == 4);
    end
    rd(8'h06, 8'h02, 1'b0);
    for (int k = 0; k < 3; k++) begin
      put(4'd5, 16'sd300);
      put(4'd2, 16'sd300);
    end
    rd(8'h05, 8'h04, 1'b0);
    irq_is(1'b1);
    rd(8'h06, 8'h02);
    rd(8'h05, 8'h00);
    irq_is(1'b0);
    $display("test touch done");
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule // tb_tri_result_irq_regs
